// ### rtl/scpw_defs.svh
/*
 Offsets, field positions, reset values and timing counts for the
 standby clock and power well control block.
 Assumes a 100 MHz system clock and an 8-bit runtime register port.
*/
`ifndef SCPW_DEFS_SVH
`define SCPW_DEFS_SVH

// Runtime register indices.
`define SCPW_OFS_WAKE_EN7      8'h10
`define SCPW_OFS_POWER_RECOVERY_CONFIG       8'h49
`define SCPW_OFS_SUPPLY_ON     8'h4a
`define SCPW_OFS_SUPPLY_PREV   8'h53
`define SCPW_OFS_DBL_CLICK     8'h5b
`define SCPW_OFS_MAKE_1        8'h5f
`define SCPW_OFS_MAKE_2        8'h60
`define SCPW_OFS_BREAK_1       8'h61
`define SCPW_OFS_BREAK_2       8'h62
`define SCPW_OFS_BREAK_3       8'h63
`define SCPW_OFS_KEY_PWRBTN    8'h64
`define SCPW_OFS_TRICKLE_CFG   8'hf0

// Field positions and reset values.
`define SCPW_BIT_CLK_ABSENT    0
`define SCPW_RST_BYTE          8'h00
`define SCPW_RST_TRICKLE_CFG   8'h00

// Rates and the divide ratio for the internally derived slow clock.
`define SCPW_CLK14_HZ          14318180
`define SCPW_SLOW_HZ           32768
`define SCPW_HALF_DIV          (`SCPW_CLK14_HZ / (2 * `SCPW_SLOW_HZ))

`endif

// ### rtl/scpw_pkg.sv
/*
 Types shared by the standby clock and power well control block.
 Assumes nothing beyond the defines header.
*/
package scpw_pkg;

   typedef enum logic [1:0] {
      SCPW_SRC_EXT,
      SCPW_SRC_HOLD,
      SCPW_SRC_INT
   } scpw_src_type;

   typedef struct packed {
      logic [7:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } scpw_req_type;

   typedef struct packed {
      logic output_mode;
      logic invert;
      logic alt_func;
   } scpw_gpio_cfg_type;

endpackage

// ### rtl/scpw_clk_switch.sv
/*
 Slow clock source selection: the external trickle clock, or a clock of
 about 32 kHz divided down from the 14 MHz input, switched without runts.
 Assumes both clock inputs are sampled levels synchronous to clock.
*/
`timescale 1ns/1ns
`default_nettype none
`include "scpw_defs.svh"

module scpw_clk_switch
(
   // System.
   input wire logic clock,
   input wire logic rstn,
   // Sources.
   input wire logic slow_clock_in,
   input wire logic clk14_in,
   input wire logic use_internal,
   // Selected clock.
   output logic slow_level_q,
   output logic slow_tick_q
);

   localparam logic [8:0] HALF_DIV = 9'(`SCPW_HALF_DIV);

   scpw_pkg::scpw_src_type src_q, src_d;
   logic clk14_prev_q, clk14_prev_d;
   logic [8:0] div_q, div_d;
   logic int_q, int_d;
   logic level_d, tick_d;
   logic cur_level;

   // The divider runs on rising edges of the 14 MHz input.
   always_comb
   begin
      clk14_prev_d = clk14_in;
      div_d = div_q;
      int_d = int_q;
      if (clk14_in && !clk14_prev_q)
      begin
         if (div_q == HALF_DIV - 9'h001)
         begin
            div_d = 9'h000;
            int_d = !int_q;
         end
         else
         begin
            div_d = div_q + 9'h001;
         end
      end
   end

   // A change of source first parks the output low, then waits for the
   // new source to be low too, so no shortened pulse escapes.
   always_comb
   begin
      src_d = src_q;
      cur_level = 1'b0;
      unique case (src_q)
         scpw_pkg::SCPW_SRC_EXT:
         begin
            cur_level = slow_clock_in;
            if (use_internal && !slow_clock_in)
               src_d = scpw_pkg::SCPW_SRC_HOLD; // R16
         end
         scpw_pkg::SCPW_SRC_INT:
         begin
            cur_level = int_q;
            if (!use_internal && !int_q)
               src_d = scpw_pkg::SCPW_SRC_HOLD; // R16
         end
         scpw_pkg::SCPW_SRC_HOLD:
         begin
            if (use_internal && !int_q)
               src_d = scpw_pkg::SCPW_SRC_INT; // R06
            else if (!use_internal && !slow_clock_in)
               src_d = scpw_pkg::SCPW_SRC_EXT; // R05
         end
      endcase
      level_d = cur_level;
      tick_d = cur_level && !slow_level_q;
   end

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         src_q <= scpw_pkg::SCPW_SRC_EXT;
         clk14_prev_q <= 1'b0;
         div_q <= 9'h000;
         int_q <= 1'b0;
         slow_level_q <= 1'b0;
         slow_tick_q <= 1'b0;
      end
      else
      begin
         src_q <= src_d;
         clk14_prev_q <= clk14_prev_d;
         div_q <= div_d;
         int_q <= int_d;
         slow_level_q <= level_d;
         slow_tick_q <= tick_d;
      end
   end

endmodule

`default_nettype wire

// ### rtl/scpw_top.sv
/*
 Standby clock and power well control: slow clock selection, main power
 gating of pins and logic, wake event output and retained registers.
 Assumes a runtime register port synchronous to clock, a standby power-on
 reset on rstn and a battery power-on reset on bat_rstn.
*/
// Behaviour
// R01 - Selected trickle clock drives watchdog, blink, recovery and key-wake timing.
// R02 - Slow-clock-absent flag is bit 0 of register 0xF0.
// R03 - Flag reads 0 with external clock present (default), 1 when absent.
// R04 - Trickle clock register is cleared by the standby power-on reset.
// R05 - Flag clear selects the external slow clock for blink and key-wake.
// R06 - Flag set selects a slow clock divided from 14 MHz.
// R07 - Without external clock, slow functions run only under main power.
// R08 - Wake events stay live on standby power and drive wake output low.
// R09 - Port 3 bits 2 and 3 revert to plain non-inverting inputs without main power.
// R10 - Main-powered wake pins act only as inputs while main power is off.
// R11 - Port 3 bits 6, 7 and port 4 bit 0 have no wake path.
// R12 - Standby reset initialises infrared, wake configuration and wake interface; wake enable 0x10 is battery-backed and only bat_rstn clears it.
// R13 - Monitor keeps its settings but runs only under main power.
// R14 - Battery registers keep contents across loss of standby power.
// R15 - Main-power-only logic is enabled only while main rail sense is high.
// R16 - Slow clock source switching is glitch-free.
`timescale 1ns/1ns
`default_nettype none
`include "scpw_defs.svh"

module scpw_top
(
   // System.
   input wire logic clock,
   input wire logic rstn,
   input wire logic bat_rstn,
   // Supply sense and clock sources.
   input wire logic main_power_on,
   input wire logic slow_clock_in,
   input wire logic clk14_in,
   // Runtime register port.
   input wire scpw_pkg::scpw_req_type reg_req,
   output logic [7:0] reg_rdata_q,
   // Slow timing for dependent logic.
   output logic slow_clock_q,
   output logic watchdog_timer_tick_q,
   output logic blink_tick_q,
   output logic recovery_tick_q,
   output logic key_wake_tick_q,
   output logic slow_func_en_q,
   // Main power gating and infrared reset release.
   output logic main_logic_en_q,
   output logic monitor_run_en_q,
   output logic infrared_rstn_q,
   // General-purpose port 3 bits 2 and 3.
   input wire scpw_pkg::scpw_gpio_cfg_type gpio_port3_bit2_cfg,
   input wire scpw_pkg::scpw_gpio_cfg_type gpio_port3_bit3_cfg,
   output scpw_pkg::scpw_gpio_cfg_type gpio_port3_bit2_eff_q,
   output scpw_pkg::scpw_gpio_cfg_type gpio_port3_bit3_eff_q,
   // Main-powered wake-capable pins.
   input wire logic [7:0] wake_pin_oe_req,
   output logic [7:0] wake_pin_oe_q,
   // Wake events.
   input wire logic [7:0] wake_src,
   input wire logic [7:0] wake_clear,
   output logic [7:0] wake_status_q,
   output logic wake_event_out_n,
   // Retained settings.
   output logic [7:0] power_recovery_cfg_q,
   output logic [7:0] supply_on_ctrl_q
);

   // Registers in the battery domain, indexed by position in BAT_OFS.
   localparam int NBAT = 11;
   localparam logic [7:0] BAT_OFS [NBAT] = '{
      `SCPW_OFS_WAKE_EN7, `SCPW_OFS_POWER_RECOVERY_CONFIG, `SCPW_OFS_SUPPLY_ON,
      `SCPW_OFS_SUPPLY_PREV, `SCPW_OFS_DBL_CLICK, `SCPW_OFS_MAKE_1,
      `SCPW_OFS_MAKE_2, `SCPW_OFS_BREAK_1, `SCPW_OFS_BREAK_2,
      `SCPW_OFS_BREAK_3, `SCPW_OFS_KEY_PWRBTN};
   localparam int IX_WAKE_EN7 = 0;
   localparam int IX_POWER_RECOVERY_CONFIG = 1;
   localparam int IX_SUPPLY_ON = 2;

   // True when the port addresses the given register.
   function automatic logic hit(input logic [7:0] addr,
                                input logic [7:0] ofs);
      hit = (addr == ofs);
   endfunction

   logic [7:0] bat_q [NBAT];
   logic [7:0] bat_d [NBAT];
   logic [7:0] trickle_cfg_q, trickle_cfg_d;
   logic [7:0] rdata_d;
   logic [7:0] wake_status_d;
   logic wake_out_n_d;
   logic slow_clock_absent;
   logic sel_level, sel_tick;
   logic slow_en_d, main_en_d;
   scpw_pkg::scpw_gpio_cfg_type gp2_d, gp3_d;
   logic [7:0] oe_d;

   assign slow_clock_absent = trickle_cfg_q[`SCPW_BIT_CLK_ABSENT]; // R02

   scpw_clk_switch u_switch
   (
      .clock(clock),
      .rstn(rstn),
      .slow_clock_in(slow_clock_in),
      .clk14_in(clk14_in),
      .use_internal(slow_clock_absent), // R05 R06
      .slow_level_q(sel_level),
      .slow_tick_q(sel_tick)
   );

   // Battery-backed registers: only the battery reset clears them, so a
   // standby power cycle leaves them intact.
   generate
      for (genvar i = 0; i < NBAT; i++)
      begin : g_bat
         always_comb
         begin
            bat_d[i] = bat_q[i];
            if (reg_req.wr && hit(reg_req.addr, BAT_OFS[i]))
               bat_d[i] = reg_req.wdata;
         end

         always_ff @(posedge clock or negedge bat_rstn)
         begin
            if (!bat_rstn)
               bat_q[i] <= `SCPW_RST_BYTE; // R14
            else
               bat_q[i] <= bat_d[i]; // R14
         end
      end
   endgenerate

   // Trickle clock register lives in the standby domain.
   always_comb
   begin
      trickle_cfg_d = trickle_cfg_q;
      if (reg_req.wr && hit(reg_req.addr, `SCPW_OFS_TRICKLE_CFG))
      begin
         trickle_cfg_d = 8'h00;
         trickle_cfg_d[`SCPW_BIT_CLK_ABSENT] =
            reg_req.wdata[`SCPW_BIT_CLK_ABSENT]; // R03
      end
   end

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         trickle_cfg_q <= `SCPW_RST_TRICKLE_CFG; // R04
      else
         trickle_cfg_q <= trickle_cfg_d;
   end

   // Read data; unmapped indices read as zero, reserved bits as zero.
   always_comb
   begin
      rdata_d = reg_rdata_q;
      if (reg_req.rd)
      begin
         rdata_d = 8'h00;
         if (hit(reg_req.addr, `SCPW_OFS_TRICKLE_CFG))
            rdata_d = trickle_cfg_q; // R02 R03
         for (int i = 0; i < NBAT; i++)
         begin
            if (hit(reg_req.addr, BAT_OFS[i]))
               rdata_d = bat_q[i];
         end
      end
   end

   // Slow functions need the external clock unless main power is on.
   always_comb
   begin
      main_en_d = main_power_on; // R15
      slow_en_d = main_power_on || !slow_clock_absent; // R07
   end

   // Main-power gating of pins.
   always_comb
   begin
      gp2_d = gpio_port3_bit2_cfg;
      gp3_d = gpio_port3_bit3_cfg;
      if (!main_power_on)
      begin
         gp2_d = '0; // R09
         gp3_d = '0; // R09
      end
      oe_d = main_power_on ? wake_pin_oe_req : 8'h00; // R10
   end

   // Wake events: sticky per source, set beats clear. Only the eight
   // wake-capable sources enter here; non-wake pins have no input. R11
   always_comb
   begin
      wake_status_d = (wake_status_q & ~wake_clear) | wake_src; // R08
      wake_out_n_d =
         !(|(wake_status_d & bat_q[IX_WAKE_EN7])); // R08
   end

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         reg_rdata_q <= 8'h00;
         slow_clock_q <= 1'b0;
         watchdog_timer_tick_q <= 1'b0;
         blink_tick_q <= 1'b0;
         recovery_tick_q <= 1'b0;
         key_wake_tick_q <= 1'b0;
         slow_func_en_q <= 1'b0;
         main_logic_en_q <= 1'b0;
         monitor_run_en_q <= 1'b0;
         infrared_rstn_q <= 1'b0; // R12
         gpio_port3_bit2_eff_q <= '0;
         gpio_port3_bit3_eff_q <= '0;
         wake_pin_oe_q <= 8'h00;
         wake_status_q <= 8'h00; // R12
         wake_event_out_n <= 1'b1; // R12
         power_recovery_cfg_q <= 8'h00;
         supply_on_ctrl_q <= 8'h00;
      end
      else
      begin
         reg_rdata_q <= rdata_d;
         slow_clock_q <= sel_level;
         watchdog_timer_tick_q <= sel_tick && slow_en_d; // R01 R07
         blink_tick_q <= sel_tick && slow_en_d; // R01 R07
         recovery_tick_q <= sel_tick && slow_en_d; // R01 R07
         key_wake_tick_q <= sel_tick && slow_en_d; // R01 R07
         slow_func_en_q <= slow_en_d;
         main_logic_en_q <= main_en_d;
         monitor_run_en_q <= main_en_d; // R13
         infrared_rstn_q <= 1'b1;
         gpio_port3_bit2_eff_q <= gp2_d;
         gpio_port3_bit3_eff_q <= gp3_d;
         wake_pin_oe_q <= oe_d;
         wake_status_q <= wake_status_d;
         wake_event_out_n <= wake_out_n_d;
         power_recovery_cfg_q <= bat_q[IX_POWER_RECOVERY_CONFIG]; // R14
         supply_on_ctrl_q <= bat_q[IX_SUPPLY_ON]; // R14
      end
   end

endmodule

`default_nettype wire

// ### verification/scpw_assertions.sv
/*
 Port-level checks for the standby clock and power well block.
 Assumes it is bound to scpw_top and sees only that module's ports.
*/
`timescale 1ns/1ns
`default_nettype none
module scpw_assertions
(
   // System.
   input wire logic clock,
   input wire logic rstn,
   input wire logic main_power_on,
   // Watched ports.
   input wire scpw_pkg::scpw_req_type reg_req,
   input wire logic [7:0] reg_rdata_q,
   input wire logic [7:0] wake_pin_oe_q,
   input wire scpw_pkg::scpw_gpio_cfg_type gpio_port3_bit2_eff_q,
   input wire logic main_logic_en_q,
   input wire logic monitor_run_en_q,
   input wire logic slow_func_en_q,
   input wire logic blink_tick_q,
   input wire logic watchdog_timer_tick_q,
   input wire logic infrared_rstn_q,
   input wire logic [7:0] wake_src,
   input wire logic [7:0] wake_status_q,
   input wire logic wake_event_out_n
);
   default clocking @(posedge clock);
   endclocking
   default disable iff (!rstn);
   sequence flag_wr;
      reg_req.wr && !reg_req.rd && reg_req.addr == 8'hf0;
   endsequence
   sequence flag_rd;
      reg_req.rd && !reg_req.wr && reg_req.addr == 8'hf0;
   endsequence
   chk_flag_readback: assert property (flag_wr ##1 flag_rd |=>
      reg_rdata_q == {7'h00, $past(reg_req.wdata[0], 2)})
      else $error("flag readback wrong");
   chk_oe_gate: assert property (!main_power_on |=>
      wake_pin_oe_q == 8'h00) else $error("pin driven without main power");
   chk_gpio_revert: assert property (!main_power_on |=>
      gpio_port3_bit2_eff_q == 3'h0) else $error("gpio not reverted");
   chk_main_follow: assert property (1'b1 |=>
      main_logic_en_q == $past(main_power_on)) else $error("main enable lag");
   chk_monitor_gate: assert property (
      monitor_run_en_q == main_logic_en_q) else $error("monitor enable wrong");
   chk_slow_main: assert property (
      main_logic_en_q |-> slow_func_en_q) else $error("slow off under main");
   chk_tick_gate: assert property (
      !slow_func_en_q [*3] |-> !blink_tick_q) else $error("tick while gated");
   chk_tick_share: assert property (
      blink_tick_q == watchdog_timer_tick_q) else $error("ticks differ");
   chk_wake_set: assert property (
      wake_src[0] |=> wake_status_q[0]) else $error("wake status not set");
   chk_wake_out: assert property (
      !wake_event_out_n |-> wake_status_q != 8'h00) else $error("wake low idle");
   chk_ir_release: assert property (
      rstn |=> infrared_rstn_q) else $error("infrared held in reset");
endmodule
bind scpw_top scpw_assertions u_scpw_assertions (.clock(clock),
   .rstn(rstn), .main_power_on(main_power_on), .reg_req(reg_req),
   .reg_rdata_q(reg_rdata_q), .wake_pin_oe_q(wake_pin_oe_q),
   .gpio_port3_bit2_eff_q(gpio_port3_bit2_eff_q),
   .main_logic_en_q(main_logic_en_q), .monitor_run_en_q(monitor_run_en_q),
   .slow_func_en_q(slow_func_en_q), .blink_tick_q(blink_tick_q),
   .watchdog_timer_tick_q(watchdog_timer_tick_q),
   .infrared_rstn_q(infrared_rstn_q), .wake_src(wake_src),
   .wake_status_q(wake_status_q), .wake_event_out_n(wake_event_out_n));
`default_nettype wire

// ### verification/scpw_wake_host.sv
/*
 Chipset side of the wake line: counts assertions and clears status.
 Assumes the same clock and reset as the block.
*/
`timescale 1ns/1ns
`default_nettype none
module scpw_wake_host
(
   // System.
   input wire logic clock,
   input wire logic rstn,
   // Wake line and acknowledge control.
   input wire logic wake_event_out_n,
   input wire logic ack_en,
   input wire logic [3:0] ack_wait,
   output logic [7:0] wake_clear,
   output int seen
);
   logic [3:0] low_q;
   logic line_q;
   always_ff @(posedge clock or negedge rstn)
      if (!rstn)
      begin
         low_q <= 4'h0;
         line_q <= 1'b1;
         wake_clear <= 8'h00;
         seen <= 0;
      end
      else
      begin
         line_q <= wake_event_out_n;
         if (line_q && !wake_event_out_n)
            seen <= seen + 1;
         low_q <= wake_event_out_n ? 4'h0 : low_q + 4'h1;
         wake_clear <= (ack_en && !wake_event_out_n && low_q == ack_wait) ?
            8'hff : 8'h00;
      end
endmodule
`default_nettype wire

// ### verification/scpw_top_bench.sv
/*
 Self-checking bench for scpw_top with the wake receiver model.
 Assumes the block's package is compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) check_count++; if ((g) !== (e)) begin n_errors++; \
   $display("BAD %s exp %h got %h", nm, e, g); end
module scpw_top_bench;
   typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;}
      scpw_row_type;
   scpw_row_type rows [13] = '{'{8'h10, 8'h5a, 8'h5a},
      '{8'h49, 8'ha5, 8'ha5}, '{8'h4a, 8'h3c, 8'h3c}, '{8'h53, 8'hc3, 8'hc3},
      '{8'h5b, 8'h11, 8'h11}, '{8'h5f, 8'h22, 8'h22}, '{8'h60, 8'h33, 8'h33},
      '{8'h61, 8'h44, 8'h44}, '{8'h62, 8'h55, 8'h55}, '{8'h63, 8'h66, 8'h66},
      '{8'h64, 8'h77, 8'h77}, '{8'hf0, 8'hff, 8'h01}, '{8'h55, 8'hff, 8'h00}};
   logic clock = 0, rstn = 0, bat_rstn = 0, main_power_on = 0;
   logic slow_clock_in = 0, clk14_in = 0, ext_on = 1, ack_en = 0;
   logic blink, ml_en, mon_en, sf_en, ir_rstn, wake_n;
   logic [7:0] oe_req = 8'ha5, wake_src = 8'h00;
   logic [7:0] wake_clear, rdata, oe, status, prc, soc;
   scpw_pkg::scpw_req_type reg_req = '0;
   scpw_pkg::scpw_gpio_cfg_type gcfg = '1, eff2, eff3;
   int n_errors = 0, check_count = 0, cyc = 0, ticks = 0, t0, seen;
   always #5 clock = ~clock;
   scpw_top u_scpw_top (.clock(clock), .rstn(rstn), .bat_rstn(bat_rstn),
      .main_power_on(main_power_on), .slow_clock_in(slow_clock_in),
      .clk14_in(clk14_in), .reg_req(reg_req), .reg_rdata_q(rdata),
      .slow_clock_q(), .watchdog_timer_tick_q(), .blink_tick_q(blink),
      .recovery_tick_q(), .key_wake_tick_q(), .slow_func_en_q(sf_en),
      .main_logic_en_q(ml_en), .monitor_run_en_q(mon_en),
      .infrared_rstn_q(ir_rstn), .gpio_port3_bit2_cfg(gcfg),
      .gpio_port3_bit3_cfg(gcfg), .gpio_port3_bit2_eff_q(eff2),
      .gpio_port3_bit3_eff_q(eff3), .wake_pin_oe_req(oe_req),
      .wake_pin_oe_q(oe), .wake_src(wake_src), .wake_clear(wake_clear),
      .wake_status_q(status), .wake_event_out_n(wake_n),
      .power_recovery_cfg_q(prc), .supply_on_ctrl_q(soc));
   scpw_wake_host u_scpw_wake_host (.clock(clock), .rstn(rstn),
      .wake_event_out_n(wake_n), .ack_en(ack_en), .ack_wait(4'h3),
      .wake_clear(wake_clear), .seen(seen));
   task automatic conclude;
      $display("errors %0d checks %0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock) reg_req <= '{a, 1'b1, 1'b0, d};
      @(posedge clock) reg_req <= '{a, 1'b0, 1'b0, d};
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clock) reg_req <= '{a, 1'b0, 1'b1, 8'h00};
      @(posedge clock) reg_req <= '{a, 1'b0, 1'b0, 8'h00};
      #1;
   endtask
   task automatic pulse(input logic [7:0] s);
      @(posedge clock) wake_src <= s;
      @(posedge clock) wake_src <= 8'h00;
      idle(2);
   endtask
   // Slow sources: 14 MHz stand-in of four cycles, external of 128.
   always @(posedge clock)
   begin
      cyc <= cyc + 1;
      clk14_in <= cyc[1];
      slow_clock_in <= ext_on & cyc[6];
      if (blink === 1'b1)
         ticks <= ticks + 1;
      if (cyc == 20000)
      begin
         n_errors++;
         conclude();
      end
   end
   initial
   begin
      idle(20);
      `CHK("ir_rstn", 1'b0, ir_rstn)
      @(posedge clock) rstn <= 1;
      bat_rstn <= 1;
      foreach (rows[i])
      begin
         rd(rows[i].a);
         `CHK("reset value", 8'h00, rdata)
         wr(rows[i].a, rows[i].d);
         rd(rows[i].a);
         `CHK("readback", rows[i].e, rdata)
      end
      `CHK("prc", 8'ha5, prc)
      `CHK("soc", 8'h3c, soc)
      $display("test registers done");
      @(posedge clock) rstn <= 0;
      idle(3);
      `CHK("ir_rstn", 1'b0, ir_rstn)
      @(posedge clock) rstn <= 1;
      idle(2);
      `CHK("ir_rstn", 1'b1, ir_rstn)
      rd(8'h49);
      `CHK("kept 49", 8'ha5, rdata)
      rd(8'hf0);
      `CHK("cleared f0", 8'h00, rdata)
      $display("test retention done");
      `CHK("eff2 off", 3'h0, eff2)
      `CHK("oe off", 8'h00, oe)
      `CHK("ml_en off", 1'b0, ml_en)
      `CHK("mon_en off", 1'b0, mon_en)
      @(posedge clock) main_power_on <= 1;
      idle(2);
      `CHK("eff2 on", 3'h7, eff2)
      `CHK("oe on", 8'ha5, oe)
      `CHK("ml_en on", 1'b1, ml_en)
      `CHK("mon_en on", 1'b1, mon_en)
      @(posedge clock) main_power_on <= 0;
      idle(2);
      `CHK("eff3 off", 3'h0, eff3)
      `CHK("oe off", 8'h00, oe)
      $display("test main power done");
      wr(8'h10, 8'h01);
      pulse(8'h01);
      `CHK("status", 8'h01, status)
      `CHK("wake_n", 1'b0, wake_n)
      idle(8);
      `CHK("wake_n held", 1'b0, wake_n)
      @(posedge clock) ack_en <= 1;
      idle(10);
      `CHK("wake_n acked", 1'b1, wake_n)
      `CHK("seen", 1, seen)
      pulse(8'h02);
      `CHK("masked status", 8'h02, status)
      `CHK("masked wake_n", 1'b1, wake_n)
      $display("test wake done");
      idle(300);
      t0 = ticks;
      idle(1280);
      `CHK("ext ticks", 1'b1, ticks - t0 >= 9 && ticks - t0 <= 11)
      @(posedge clock) ext_on <= 0;
      // Write then read back to back, so the readback check sees it.
      @(posedge clock) reg_req <= '{8'hf0, 1'b1, 1'b0, 8'h01};
      @(posedge clock) reg_req <= '{8'hf0, 1'b0, 1'b1, 8'h00};
      @(posedge clock) reg_req <= '{8'hf0, 1'b0, 1'b0, 8'h00};
      #1;
      `CHK("b2b f0", 8'h01, rdata)
      idle(2000);
      t0 = ticks;
      idle(2000);
      `CHK("gated ticks", 0, ticks - t0)
      `CHK("sf_en", 1'b0, sf_en)
      @(posedge clock) main_power_on <= 1;
      idle(300);
      t0 = ticks;
      idle(4000);
      `CHK("int ticks", 1'b1, ticks - t0 >= 2 && ticks - t0 <= 3)
      $display("test slow clock done");
      conclude();
   end
endmodule
`default_nettype wire
